// ===== rtl/exec_pkg.sv
package exec_pkg;

    localparam int DATA_W = 8;
    localparam int BIT_SEL_W = 3;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [7:0] STEP_ONE = 8'h01;
    localparam logic [7:0] WREG_RESET = 8'h00;
    // Instruction cycles spent by a taken skip: own cycle, dummy, discarded fetch
    localparam int SKIP_CYCLES = 3;

    typedef enum logic [3:0] {
        nop_op,
        long_dec_skip_zero_op,
        long_dec_skip_zero_to_wreg_op,
        long_set_bits_op,
        long_set_one_bit_op,
        long_inc_skip_zero_op,
        long_inc_skip_zero_to_wreg_op,
        long_skip_bit_nonzero_op,
        long_skip_nonzero_op,
        long_subtract_op,
        long_subtract_to_mem_op,
        long_nibble_exchange_op,
        long_nibble_exchange_to_wreg_op
    } op_e;

    typedef struct packed {
        logic signed_range_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
        logic signed_carry_flag;
        logic chained_zero_flag;
    } flags_s;

    localparam flags_s FLAGS_RESET = '0;

    typedef struct packed {
        logic wreg_we;
        logic [7:0] wreg_val;
        logic mem_we;
        logic [7:0] mem_val;
        flags_s flags;
        logic skip;
    } result_s;

endpackage

// ===== rtl/long_op_alu.sv
`timescale 1ns/1ps
module long_op_alu (
    input wire exec_pkg::op_e i_op,
    input wire logic [7:0] i_mem,
    input wire logic [7:0] i_wreg,
    input wire logic [2:0] i_bit_sel,
    input wire exec_pkg::flags_s i_flags,
    output exec_pkg::result_s o_result
);

    // Unsigned difference with the borrow in bit 8
    function automatic logic [8:0] sub_borrow(input logic [7:0] a, input logic [7:0] b);
        sub_borrow = {1'b0, a} - {1'b0, b};
    endfunction

    wire logic [7:0] dec_val = 8'(sub_borrow(i_mem, exec_pkg::STEP_ONE));
    wire logic [7:0] inc_val = i_mem + exec_pkg::STEP_ONE;
    wire logic [8:0] diff9 = sub_borrow(i_wreg, i_mem);
    wire logic [8:0] half9 = sub_borrow({4'h0, i_wreg[3:0]}, {4'h0, i_mem[3:0]});
    wire logic [7:0] diff = diff9[7:0];
    wire logic sub_ov = (i_wreg[7] ^ i_mem[7]) & (i_wreg[7] ^ diff[7]);
    wire logic [7:0] swap_val = {i_mem[3:0], i_mem[7:4]};
    wire logic [7:0] bit_mask = exec_pkg::STEP_ONE << i_bit_sel;
    wire exec_pkg::flags_s sub_flags = '{
        signed_range_flag: sub_ov,
        zero_flag: (diff == 8'h00),
        half_carry_flag: ~half9[4],
        carry_flag: ~diff9[8],
        signed_carry_flag: sub_ov ^ diff[7],
        chained_zero_flag: (diff == 8'h00)
    };

    always_comb begin
        o_result = '{wreg_we: 1'b0, wreg_val: i_wreg, mem_we: 1'b0, mem_val: i_mem,
                     flags: i_flags, skip: 1'b0};
        case (i_op)
            exec_pkg::long_dec_skip_zero_op: begin
                o_result.mem_we = 1'b1;
                o_result.mem_val = dec_val;
                o_result.skip = (dec_val == 8'h00);
            end
            exec_pkg::long_dec_skip_zero_to_wreg_op: begin
                o_result.wreg_we = 1'b1;
                o_result.wreg_val = dec_val;
                o_result.skip = (dec_val == 8'h00);
            end
            exec_pkg::long_set_bits_op: begin
                o_result.mem_we = 1'b1;
                o_result.mem_val = exec_pkg::ALL_ONES;
            end
            exec_pkg::long_set_one_bit_op: begin
                o_result.mem_we = 1'b1;
                o_result.mem_val = i_mem | bit_mask;
            end
            exec_pkg::long_inc_skip_zero_op: begin
                o_result.mem_we = 1'b1;
                o_result.mem_val = inc_val;
                o_result.skip = (inc_val == 8'h00);
            end
            exec_pkg::long_inc_skip_zero_to_wreg_op: begin
                o_result.wreg_we = 1'b1;
                o_result.wreg_val = inc_val;
                o_result.skip = (inc_val == 8'h00);
            end
            exec_pkg::long_skip_bit_nonzero_op: begin
                o_result.skip = |(i_mem & bit_mask);
            end
            exec_pkg::long_skip_nonzero_op: begin
                // Read value is written back unchanged
                o_result.mem_we = 1'b1;
                o_result.skip = (i_mem != 8'h00);
            end
            exec_pkg::long_subtract_op: begin
                o_result.wreg_we = 1'b1;
                o_result.wreg_val = diff;
                o_result.flags = sub_flags;
            end
            exec_pkg::long_subtract_to_mem_op: begin
                o_result.mem_we = 1'b1;
                o_result.mem_val = diff;
                o_result.flags = sub_flags;
            end
            exec_pkg::long_nibble_exchange_op: begin
                o_result.mem_we = 1'b1;
                o_result.mem_val = swap_val;
            end
            exec_pkg::long_nibble_exchange_to_wreg_op: begin
                o_result.wreg_we = 1'b1;
                o_result.wreg_val = swap_val;
            end
            default: begin
                o_result.skip = 1'b0;
            end
        endcase
    end

endmodule

// ===== rtl/long_op_exec.sv
// Notes on behaviour
// - Decrement byte, write back, skip if zero
// - Taken skip costs three instruction cycles total
// - Decrement into work register, memory untouched, skip
// - Byte set to all ones, flags kept
// - Selected bit set, others and flags kept
// - Increment byte, write back, skip on wrap
// - Increment into work register, skip if zero
// - Skip when selected bit is one
// - Rewrite byte unchanged, skip if nonzero
// - Work register minus byte into work register
// - Work register minus byte into memory
// - Carry clear on borrow, set otherwise
// - Subtracts update all six arithmetic flags
// - Swap byte nibbles in place, flags kept
// - Swapped byte into work register only
`timescale 1ns/1ps
module long_op_exec (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_op_valid,
    input wire exec_pkg::op_e i_op,
    input wire logic [7:0] i_mem_rdata,
    input wire logic [2:0] i_bit_sel,
    output logic o_ready,
    output logic o_mem_we,
    output logic [7:0] o_mem_wdata,
    output logic [7:0] o_wreg,
    output exec_pkg::flags_s o_flags,
    output logic o_skip,
    output logic o_squashed
);

    typedef enum logic [1:0] {st_run, st_dummy, st_discard} state_e;

    state_e state_reg;
    state_e state_next;
    logic ready_reg;
    logic mem_we_reg;
    logic [7:0] mem_wdata_reg;
    logic [7:0] wreg_reg;
    exec_pkg::flags_s flags_reg;
    logic skip_reg;
    logic squashed_reg;
    exec_pkg::result_s res;

    long_op_alu long_op_alu_inst (
        .i_op(i_op),
        .i_mem(i_mem_rdata),
        .i_wreg(wreg_reg),
        .i_bit_sel(i_bit_sel),
        .i_flags(flags_reg),
        .o_result(res)
    );

    wire logic accept = i_op_valid & ready_reg;
    wire logic exec_now = accept & (state_reg == st_run);
    // An op taken in the discard slot is the skipped fetch: it leaves no trace
    wire logic squash_now = accept & (state_reg == st_discard);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            st_run: begin
                if (exec_now && res.skip) begin
                    state_next = st_dummy;
                end
            end
            st_dummy: begin
                state_next = st_discard;
            end
            st_discard: begin
                if (squash_now) begin
                    state_next = st_run;
                end
            end
            default: begin
                state_next = st_run;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_reg <= st_run;
            ready_reg <= 1'b1;
            mem_we_reg <= 1'b0;
            mem_wdata_reg <= exec_pkg::WREG_RESET;
            wreg_reg <= exec_pkg::WREG_RESET;
            flags_reg <= exec_pkg::FLAGS_RESET;
            skip_reg <= 1'b0;
            squashed_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_reg <= (state_next != st_dummy);
            mem_we_reg <= exec_now & res.mem_we;
            mem_wdata_reg <= res.mem_val;
            if (exec_now && res.wreg_we) begin
                wreg_reg <= res.wreg_val;
            end
            if (exec_now) begin
                flags_reg <= res.flags;
            end
            skip_reg <= exec_now & res.skip;
            squashed_reg <= squash_now;
        end
    end

    assign o_ready = ready_reg;
    assign o_mem_we = mem_we_reg;
    assign o_mem_wdata = mem_wdata_reg;
    assign o_wreg = wreg_reg;
    assign o_flags = flags_reg;
    assign o_skip = skip_reg;
    assign o_squashed = squashed_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    property p_dec_skip;
        exec_now && i_op == exec_pkg::long_dec_skip_zero_op |=>
            o_mem_we && o_mem_wdata == 8'($past(i_mem_rdata) - 8'h01)
            && o_skip == ($past(i_mem_rdata) == 8'h01);
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("decrement-skip result wrong");

    property p_skip_cycles;
        exec_now && res.skip |=> !o_ready ##1 (o_ready && state_reg == st_discard);
    endproperty
    a_skip_cycles: assert property (p_skip_cycles) else $error("skip timing wrong");

    property p_dec_wreg;
        exec_now && i_op == exec_pkg::long_dec_skip_zero_to_wreg_op |=>
            !o_mem_we && o_wreg == 8'($past(i_mem_rdata) - 8'h01) && o_skip == (o_wreg == 8'h00);
    endproperty
    a_dec_wreg: assert property (p_dec_wreg) else $error("decrement to work register wrong");

    property p_set_bits;
        exec_now && i_op == exec_pkg::long_set_bits_op |=>
            o_mem_we && o_mem_wdata == 8'hff && $stable(o_flags) && !o_skip;
    endproperty
    a_set_bits: assert property (p_set_bits) else $error("byte set wrong");

    property p_set_bit;
        exec_now && i_op == exec_pkg::long_set_one_bit_op |=>
            o_mem_wdata == ($past(i_mem_rdata) | (8'h01 << $past(i_bit_sel))) && $stable(o_flags);
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("bit set wrong");

    property p_inc_skip;
        exec_now && i_op == exec_pkg::long_inc_skip_zero_op |=>
            o_mem_we && o_skip == ($past(i_mem_rdata) == 8'hff) && $stable(o_flags);
    endproperty
    a_inc_skip: assert property (p_inc_skip) else $error("increment-skip wrong");

    property p_bit_skip;
        exec_now && i_op == exec_pkg::long_skip_bit_nonzero_op |=>
            !o_mem_we && o_skip == $past(i_mem_rdata[i_bit_sel]);
    endproperty
    a_bit_skip: assert property (p_bit_skip) else $error("bit-test skip wrong");

    property p_sub_carry;
        exec_now && (i_op == exec_pkg::long_subtract_op || i_op == exec_pkg::long_subtract_to_mem_op) |=>
            o_flags.carry_flag == ($past(o_wreg) >= $past(i_mem_rdata));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

    property p_swap;
        exec_now && i_op == exec_pkg::long_nibble_exchange_op |=>
            o_mem_we && o_mem_wdata == {$past(i_mem_rdata[3:0]), $past(i_mem_rdata[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong");

    property p_squash;
        squash_now |=> o_squashed && !o_mem_we && !o_skip && $stable(o_wreg) && $stable(o_flags);
    endproperty
    a_squash: assert property (p_squash) else $error("skipped instruction had effect");

    property p_inc_wreg;
        exec_now && i_op == exec_pkg::long_inc_skip_zero_to_wreg_op |=>
            !o_mem_we && o_wreg == 8'($past(i_mem_rdata) + 8'h01) && o_skip == (o_wreg == 8'h00);
    endproperty
    a_inc_wreg: assert property (p_inc_wreg) else $error("increment to work register wrong");

    property p_skip_nz;
        exec_now && i_op == exec_pkg::long_skip_nonzero_op |=>
            o_mem_we && o_mem_wdata == $past(i_mem_rdata) && o_skip == ($past(i_mem_rdata) != 8'h00);
    endproperty
    a_skip_nz: assert property (p_skip_nz) else $error("nonzero skip wrong");

    property p_sub_wreg;
        exec_now && i_op == exec_pkg::long_subtract_op |=>
            !o_mem_we && o_wreg == 8'($past(o_wreg) - $past(i_mem_rdata));
    endproperty
    a_sub_wreg: assert property (p_sub_wreg) else $error("subtract to work register wrong");

    property p_sub_mem;
        exec_now && i_op == exec_pkg::long_subtract_to_mem_op |=>
            o_mem_we && $stable(o_wreg) && o_mem_wdata == 8'($past(o_wreg) - $past(i_mem_rdata));
    endproperty
    a_sub_mem: assert property (p_sub_mem) else $error("subtract to memory wrong");

    // Zero, chained zero and half carry follow the difference of the sampled operands
    property p_sub_flags;
        exec_now && (i_op == exec_pkg::long_subtract_op || i_op == exec_pkg::long_subtract_to_mem_op) |=>
            o_flags.zero_flag == ($past(o_wreg) == $past(i_mem_rdata))
            && o_flags.chained_zero_flag == o_flags.zero_flag
            && o_flags.half_carry_flag == ($past(o_wreg[3:0]) >= $past(i_mem_rdata[3:0]));
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

    property p_swap_wreg;
        exec_now && i_op == exec_pkg::long_nibble_exchange_to_wreg_op |=>
            !o_mem_we && o_wreg == {$past(i_mem_rdata[3:0]), $past(i_mem_rdata[7:4])} && $stable(o_flags);
    endproperty
    a_swap_wreg: assert property (p_swap_wreg) else $error("nibble swap to work register wrong");

    // The dummy slot never stretches past one cycle
    property p_dummy_once;
        !o_ready |=> o_ready;
    endproperty
    a_dummy_once: assert property (p_dummy_once) else $error("ready low too long");

endmodule

// ===== testbench/long_skip_set_sub_swap_ops_tb.sv
`timescale 1ns/1ps
module long_skip_set_sub_swap_ops_tb;
    logic i_clk, i_reset_n, i_op_valid;
    exec_pkg::op_e i_op;
    logic [7:0] i_mem_rdata, o_mem_wdata, o_wreg, ew;
    logic [2:0] i_bit_sel;
    logic o_ready, o_mem_we, o_skip, o_squashed;
    exec_pkg::flags_s o_flags, ef;
    int fail_count = 0;
    int checks = 0;

    long_op_exec long_op_exec_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_op_valid(i_op_valid),
        .i_op(i_op), .i_mem_rdata(i_mem_rdata), .i_bit_sel(i_bit_sel), .o_ready(o_ready),
        .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata), .o_wreg(o_wreg), .o_flags(o_flags),
        .o_skip(o_skip), .o_squashed(o_squashed));

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Expected subtract flags, worked out independently of the design
    function automatic exec_pkg::flags_s sflags(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        r = a - b;
        sflags.signed_range_flag = (a[7] != b[7]) && (r[7] != a[7]);
        sflags.zero_flag = (r == 8'h00);
        sflags.half_carry_flag = (a[3:0] >= b[3:0]);
        sflags.carry_flag = (a >= b);
        sflags.signed_carry_flag = sflags.signed_range_flag ^ r[7];
        sflags.chained_zero_flag = (r == 8'h00);
    endfunction

    task automatic step(input exec_pkg::op_e o, input logic [7:0] m, input logic [2:0] b);
        @(posedge i_clk);
        i_op_valid <= 1'b1;
        i_op <= o;
        i_mem_rdata <= m;
        i_bit_sel <= b;
        @(posedge i_clk);
        i_op_valid <= 1'b0;
        #1;
    endtask

    // Caller sets ew and ef to the expected work register and flags first
    task automatic run(input exec_pkg::op_e o, input logic [7:0] m, input logic [2:0] b,
                       input logic we, input logic [7:0] wd, input logic sk);
        step(o, m, b);
        chk(o_mem_we, we);
        if (we)
            chk(o_mem_wdata, wd);
        chk(o_skip, sk);
        chk(o_wreg, ew);
        chk({2'b00, o_flags}, {2'b00, ef});
        chk(o_ready, !sk);
        chk(o_squashed, 1'b0);
        if (sk) begin
            // Discard slot: a set-all op here must leave no trace
            step(exec_pkg::long_set_bits_op, 8'h00, 3'h0);
            chk(o_squashed, 1'b1);
            chk(o_mem_we, 1'b0);
            chk(o_wreg, ew);
            chk({2'b00, o_flags}, {2'b00, ef});
        end
    endtask

    task automatic t_reset;
        chk(o_ready, 1'b1);
        chk(o_mem_we, 1'b0);
        chk(o_wreg, 8'h00);
        chk({2'b00, o_flags}, 8'h00);
        chk(o_skip, 1'b0);
        chk(o_squashed, 1'b0);
        $display("test reset done");
    endtask

    task automatic t_sub;
        logic [7:0] sa [4] = '{8'h05, 8'h03, 8'h05, 8'h80};
        logic [7:0] sb [4] = '{8'h03, 8'h05, 8'h05, 8'h01};
        for (int i = 0; i < 4; i++) begin
            ew = sa[i];
            run(exec_pkg::long_inc_skip_zero_to_wreg_op, sa[i] - 8'h01, 3'h0, 1'b0, 8'h00, 1'b0);
            ef = sflags(sa[i], sb[i]);
            ew = sa[i] - sb[i];
            run(exec_pkg::long_subtract_op, sb[i], 3'h0, 1'b0, 8'h00, 1'b0);
            ew = sa[i];
            run(exec_pkg::long_inc_skip_zero_to_wreg_op, sa[i] - 8'h01, 3'h0, 1'b0, 8'h00, 1'b0);
            ef = sflags(sa[i], sb[i]);
            run(exec_pkg::long_subtract_to_mem_op, sb[i], 3'h0, 1'b1, sa[i] - sb[i], 1'b0);
        end
        $display("test subtract done");
    endtask

    task automatic t_dec_inc;
        run(exec_pkg::long_dec_skip_zero_op, 8'h01, 3'h0, 1'b1, 8'h00, 1'b1);
        run(exec_pkg::long_dec_skip_zero_op, 8'h00, 3'h0, 1'b1, 8'hff, 1'b0);
        ew = 8'h00;
        run(exec_pkg::long_dec_skip_zero_to_wreg_op, 8'h01, 3'h0, 1'b0, 8'h00, 1'b1);
        ew = 8'h7f;
        run(exec_pkg::long_dec_skip_zero_to_wreg_op, 8'h80, 3'h0, 1'b0, 8'h00, 1'b0);
        run(exec_pkg::long_inc_skip_zero_op, 8'hff, 3'h0, 1'b1, 8'h00, 1'b1);
        run(exec_pkg::long_inc_skip_zero_op, 8'h7f, 3'h0, 1'b1, 8'h80, 1'b0);
        ew = 8'h00;
        run(exec_pkg::long_inc_skip_zero_to_wreg_op, 8'hff, 3'h0, 1'b0, 8'h00, 1'b1);
        ew = 8'h05;
        run(exec_pkg::long_inc_skip_zero_to_wreg_op, 8'h04, 3'h0, 1'b0, 8'h00, 1'b0);
        $display("test dec_inc done");
    endtask

    task automatic t_set_test;
        run(exec_pkg::long_set_bits_op, 8'h5a, 3'h0, 1'b1, 8'hff, 1'b0);
        for (int i = 0; i < 8; i++) begin
            run(exec_pkg::long_set_one_bit_op, 8'h24, i[2:0], 1'b1, 8'(8'h24 | (8'h01 << i)), 1'b0);
            run(exec_pkg::long_skip_bit_nonzero_op, 8'ha5, i[2:0], 1'b0, 8'h00, 1'(8'ha5 >> i));
        end
        $display("test set_test done");
    endtask

    task automatic t_nz_swap;
        run(exec_pkg::long_skip_nonzero_op, 8'h3c, 3'h0, 1'b1, 8'h3c, 1'b1);
        run(exec_pkg::long_skip_nonzero_op, 8'h00, 3'h0, 1'b1, 8'h00, 1'b0);
        run(exec_pkg::long_nibble_exchange_op, 8'h3c, 3'h0, 1'b1, 8'hc3, 1'b0);
        ew = 8'h21;
        run(exec_pkg::long_nibble_exchange_to_wreg_op, 8'h12, 3'h0, 1'b0, 8'h00, 1'b0);
        $display("test nz_swap done");
    endtask

    // Reset lands in the discard slot; the next op must execute, not be dropped
    task automatic t_mid_reset;
        run(exec_pkg::nop_op, 8'h99, 3'h5, 1'b0, 8'h00, 1'b0);
        step(exec_pkg::long_skip_nonzero_op, 8'h01, 3'h0);
        chk(o_skip, 8'h01);
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1;
        t_reset();
        ew = 8'h00;
        ef = '0;
        run(exec_pkg::long_nibble_exchange_op, 8'h5a, 3'h0, 1'b1, 8'ha5, 1'b0);
        $display("test mid_reset done");
    endtask

    initial begin
        i_reset_n = 1'b0;
        i_op_valid = 1'b0;
        i_op = exec_pkg::nop_op;
        i_mem_rdata = 8'h00;
        i_bit_sel = 3'h0;
        ew = 8'h00;
        ef = '0;
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1;
        t_reset();
        // Subtracts first so flags are nonzero while later ops must keep them
        t_sub();
        t_dec_inc();
        t_set_test();
        t_nz_swap();
        t_mid_reset();
        wrap_up();
    end

    // Whole run is about 126 cycles; this allows ample margin
    initial begin
        #20000;
        fail_count++;
        wrap_up();
    end
endmodule
